/* File: hw/adc_seq_pkg.sv */
// Package: register map, field positions, reset values and enumerations
package adc_seq_pkg;

	// ==========================================
	// Widths
	localparam int DATA_W = 32;
	localparam int RESULT_W = 16;
	localparam int PIN_COUNT = 16;
	localparam int BUF_WORDS = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 6;

	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_CTRL3 = 8'h08;
	localparam logic [7:0] OFS_SCAN = 8'h0c;
	localparam logic [7:0] OFS_PINCFG = 8'h10;
	localparam logic [7:0] OFS_PORT = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_BUF_FIRST = 8'h40;
	localparam logic [7:0] OFS_BUF_LAST = 8'h7c;

	// ==========================================
	// Control register one fields
	localparam int C1_MODULE_ON = 15;
	localparam int C1_TRIG_LO = 5;
	localparam int C1_TRIG_HI = 7;
	localparam int C1_SIMSAMP = 3;
	localparam int C1_AUTOSAMP = 2;
	localparam int C1_DONE = 0;
	localparam logic [15:0] C1_WMASK = 16'h80ec;

	// Control register two fields
	localparam int C2_CHCNT_LO = 8;
	localparam int C2_CHCNT_HI = 9;
	localparam int C2_HALF = 7;
	localparam int C2_SPI_LO = 2;
	localparam int C2_SPI_HI = 5;
	localparam int C2_SPLIT = 1;
	localparam int C2_ALT = 0;
	localparam logic [15:0] C2_WMASK = 16'h033f;

	// Status register fields
	localparam int ST_PTR_LO = 0;
	localparam int ST_CNT_LO = 8;

	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [PIN_COUNT-1:0] PINCFG_RST = 16'h0000;

	// ==========================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	// Bus slave states
	typedef enum logic [1:0]
	{
		BS_IDLE = 2'b01,
		BS_RWAIT = 2'b10
	} bus_state_t;

endpackage

/* File: hw/pin_config.sv */
// Analog/digital pin selection, input buffer gating and masked port readback
`timescale 1ns/1ps
`default_nettype none

module pin_config
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cfg_we,
	input wire logic [adc_seq_pkg::PIN_COUNT-1:0] cfg_wdata,
	input wire logic [adc_seq_pkg::PIN_COUNT-1:0] pin_in,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] pin_digital_select,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] digital_in_enable,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] mux_to_ground,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] port_read
);

	logic [adc_seq_pkg::PIN_COUNT-1:0] cfg_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] cfg_d;
	logic [adc_seq_pkg::PIN_COUNT-1:0] sync1_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] sync2_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] en_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] gnd_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] rd_q;
	logic [adc_seq_pkg::PIN_COUNT-1:0] en_d;
	logic [adc_seq_pkg::PIN_COUNT-1:0] rd_d;

	// ==========================================
	// Next values: a clear bit means analog input
	always_comb
	begin
		cfg_d = cfg_we ? cfg_wdata : cfg_q;
		en_d = cfg_d; // R03
		rd_d = sync2_q & cfg_q; // R05
	end

	// Registers; configuration clears to all analog
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_q <= adc_seq_pkg::PINCFG_RST; // R02
			sync1_q <= '0;
			sync2_q <= '0;
			en_q <= '0;
			gnd_q <= '0;
			rd_q <= '0;
		end
		else if (clk_en)
		begin
			cfg_q <= cfg_d; // R01
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			en_q <= en_d; // R03
			gnd_q <= cfg_d; // R04
			rd_q <= rd_d;
		end
	end

	assign pin_digital_select = cfg_q;
	assign digital_in_enable = en_q;
	assign mux_to_ground = gnd_q;
	assign port_read = rd_q;

endmodule

`default_nettype wire

/* File: hw/adc_seq_ctrl.sv */
// Converter control: power, result buffer sequencing, done and half flags, register slave
//
// Behaviour
// R01: A pin with a clear digital-select bit acts as analog input.
// R02: Pin configuration resets to zero, so all pins start analog.
// R03: Analog pins have their digital input buffer disabled.
// R04: Digital pins tie their analog multiplexer input to analog ground.
// R05: Port reads return zero for every analog pin.
// R06: Module-on at control one bit 15 powers the converter.
// R07: Module-on clear powers down digital and analog parts.
// R08: Software waits the analog settling time after switching on.
// R09: Software leaves sequencing settings alone while the module is on.
// R10: Each conversion goes to the next entry of a sixteen-word buffer.
// R11: Interrupt once the programmed number of results is stored.
// R12: Single or sequential modes: count field N-1 gives N conversions.
// R13: Simultaneous: N-1 gives 2N (two channels) or 4N (four channels).
// R14: Software keeps conversions per interrupt at sixteen or fewer.
// R15: Two-channel simultaneous: software keeps count field below eight.
// R16: Four-channel simultaneous: software keeps count field below four.
// R17: Done flag at control one bit 0 sets on interrupt, clears on next sequence.
// R18: Split mode uses two eight-word halves, alternating per interrupt.
// R19: Split mode: software keeps eight or fewer conversions per interrupt.
// R20: Split clear uses the whole sixteen-word buffer.
// R21: Control two bit 7 shows the half being written.
// R22: Software should use split mode if it unloads slowly.
// R23: Every interrupt restarts sequencing from its first step.
// R24: Channel count 00 is CH0, 01 is CH0-CH1, 1x is CH0-CH3.
// R25: Simultaneous bit 0 is sequential, 1 samples all channels together.
// R26: Results ascend within the region; pointer returns to start each interrupt.
// R27: Half flag resets to zero so the lower half fills first.
`timescale 1ns/1ps
`default_nettype none

module adc_seq_ctrl
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic conv_valid,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] conv_data,
	input wire logic seq_start,
	input wire logic [adc_seq_pkg::PIN_COUNT-1:0] pin_in,
	output logic converter_power,
	output logic conv_irq,
	output logic seq_restart,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] digital_in_enable,
	output logic [adc_seq_pkg::PIN_COUNT-1:0] mux_to_ground
);

	// ==========================================
	// Decoding functions

	// Conversions per interrupt from channel count, sampling mode and count field
	function automatic logic [adc_seq_pkg::CNT_W-1:0] conv_target
	(
		input logic [1:0] chcnt,
		input logic simsamp,
		input logic [3:0] spi
	);
		logic [adc_seq_pkg::CNT_W-1:0] n;
		n = {2'h0, spi} + 6'h01; // R12
		if (!simsamp || chcnt == 2'h0)
			conv_target = n; // R25
		else if (chcnt == 2'h1)
			conv_target = {n[4:0], 1'b0}; // R13 R24
		else
			conv_target = {n[3:0], 2'h0}; // R13 R24
	endfunction

	// Buffer entry for a region offset
	function automatic logic [adc_seq_pkg::PTR_W-1:0] buf_index
	(
		input logic split,
		input logic half,
		input logic [adc_seq_pkg::PTR_W-1:0] off
	);
		buf_index = split ? {half, off[2:0]} : off; // R18 R20
	endfunction

	// ==========================================
	// Declarations
	adc_seq_pkg::bus_state_t bus_q;
	adc_seq_pkg::bus_state_t bus_d;
	logic [7:0] addr_q;
	logic [7:0] addr_d;
	logic wr_pend_q;
	logic wr_pend_d;
	logic hreadyout_q;
	logic hreadyout_d;
	logic [31:0] hrdata_q;
	logic [31:0] hrdata_d;
	logic [15:0] ctrl1_q;
	logic [15:0] ctrl1_d;
	logic [15:0] ctrl2_q;
	logic [15:0] ctrl2_d;
	logic [15:0] ctrl3_q;
	logic [15:0] ctrl3_d;
	logic [15:0] scan_q;
	logic [15:0] scan_d;
	logic [adc_seq_pkg::CNT_W-1:0] cnt_q;
	logic [adc_seq_pkg::CNT_W-1:0] cnt_d;
	logic [adc_seq_pkg::PTR_W-1:0] off_q;
	logic [adc_seq_pkg::PTR_W-1:0] off_d;
	logic half_q;
	logic half_d;
	logic done_q;
	logic done_d;
	logic irq_q;
	logic irq_d;
	logic restart_q;
	logic power_q;
	logic [adc_seq_pkg::RESULT_W-1:0] result_mem [adc_seq_pkg::BUF_WORDS];
	logic accept;
	logic wr_now;
	logic module_on;
	logic split;
	logic take_conv;
	logic last_conv;
	logic [adc_seq_pkg::PTR_W-1:0] wr_idx;
	logic [adc_seq_pkg::PIN_COUNT-1:0] pincfg;
	logic [adc_seq_pkg::PIN_COUNT-1:0] port_read;

	// ==========================================
	// Pin configuration and port readback
	pin_config u_pin_config
	(
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.cfg_we(wr_now && addr_q == adc_seq_pkg::OFS_PINCFG),
		.cfg_wdata(hwdata[adc_seq_pkg::PIN_COUNT-1:0]),
		.pin_in(pin_in),
		.pin_digital_select(pincfg),
		.digital_in_enable(digital_in_enable),
		.mux_to_ground(mux_to_ground),
		.port_read(port_read)
	);

	// ==========================================
	// Bus slave: zero-wait writes, one wait state on reads
	assign accept = hsel && hready && htrans == adc_seq_pkg::HTRANS_NONSEQ;
	assign wr_now = wr_pend_q && hreadyout_q;

	always_comb
	begin
		bus_d = bus_q;
		addr_d = addr_q;
		wr_pend_d = 1'b0;
		hreadyout_d = 1'b1;
		hrdata_d = hrdata_q;
		unique case (bus_q)
			adc_seq_pkg::BS_IDLE:
			begin
				if (accept)
				begin
					addr_d = haddr[7:0];
					wr_pend_d = hwrite;
					if (!hwrite)
					begin
						bus_d = adc_seq_pkg::BS_RWAIT;
						hreadyout_d = 1'b0;
					end
				end
			end
			adc_seq_pkg::BS_RWAIT:
			begin
				bus_d = adc_seq_pkg::BS_IDLE;
				hrdata_d = 32'h0000_0000;
				if (addr_q >= adc_seq_pkg::OFS_BUF_FIRST && addr_q <= adc_seq_pkg::OFS_BUF_LAST
					&& addr_q[1:0] == 2'h0)
					hrdata_d[15:0] = result_mem[addr_q[5:2]]; // R10
				else
				begin
					unique case (addr_q)
						adc_seq_pkg::OFS_CTRL1: hrdata_d[15:0] = ctrl1_q;
						adc_seq_pkg::OFS_CTRL2: hrdata_d[15:0] = ctrl2_q;
						adc_seq_pkg::OFS_CTRL3: hrdata_d[15:0] = ctrl3_q;
						adc_seq_pkg::OFS_SCAN: hrdata_d[15:0] = scan_q;
						adc_seq_pkg::OFS_PINCFG: hrdata_d[15:0] = pincfg;
						adc_seq_pkg::OFS_PORT: hrdata_d[15:0] = port_read; // R05
						adc_seq_pkg::OFS_STATUS:
						begin
							hrdata_d[adc_seq_pkg::ST_PTR_LO +: adc_seq_pkg::PTR_W] = wr_idx;
							hrdata_d[adc_seq_pkg::ST_CNT_LO +: adc_seq_pkg::CNT_W] = cnt_q;
						end
						default: hrdata_d = 32'h0000_0000;
					endcase
				end
			end
		endcase
	end

	// Bus slave registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_q <= adc_seq_pkg::BS_IDLE;
			addr_q <= 8'h00;
			wr_pend_q <= 1'b0;
			hreadyout_q <= 1'b1;
			hrdata_q <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			bus_q <= bus_d;
			addr_q <= addr_d;
			wr_pend_q <= wr_pend_d;
			hreadyout_q <= hreadyout_d;
			hrdata_q <= hrdata_d;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = adc_seq_pkg::HRESP_OKAY;

	// ==========================================
	// Control registers; status bits are driven by hardware only
	assign module_on = ctrl1_q[adc_seq_pkg::C1_MODULE_ON];
	assign split = ctrl2_q[adc_seq_pkg::C2_SPLIT];

	always_comb
	begin
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		ctrl3_d = ctrl3_q;
		scan_d = scan_q;
		if (wr_now && addr_q == adc_seq_pkg::OFS_CTRL1)
			ctrl1_d = hwdata[15:0] & adc_seq_pkg::C1_WMASK; // R06 R07
		if (wr_now && addr_q == adc_seq_pkg::OFS_CTRL2)
			ctrl2_d = hwdata[15:0] & adc_seq_pkg::C2_WMASK;
		if (wr_now && addr_q == adc_seq_pkg::OFS_CTRL3)
			ctrl3_d = hwdata[15:0];
		if (wr_now && addr_q == adc_seq_pkg::OFS_SCAN)
			scan_d = hwdata[15:0];
		ctrl1_d[adc_seq_pkg::C1_DONE] = done_d; // R17
		ctrl2_d[adc_seq_pkg::C2_HALF] = half_d; // R21
	end

	// ==========================================
	// Result sequencing; everything idles while the module is off
	assign take_conv = conv_valid && module_on; // R07
	assign last_conv = cnt_q + 6'h01 >= conv_target(ctrl2_q[adc_seq_pkg::C2_CHCNT_HI:adc_seq_pkg::C2_CHCNT_LO],
		ctrl1_q[adc_seq_pkg::C1_SIMSAMP], ctrl2_q[adc_seq_pkg::C2_SPI_HI:adc_seq_pkg::C2_SPI_LO]);
	assign wr_idx = buf_index(split, half_q, off_q);

	always_comb
	begin
		cnt_d = cnt_q;
		off_d = off_q;
		half_d = split ? half_q : 1'b0; // R27
		irq_d = 1'b0;
		done_d = done_q;
		if (!module_on)
		begin
			cnt_d = '0;
			off_d = '0;
		end
		else if (take_conv)
		begin
			if (last_conv)
			begin
				irq_d = 1'b1; // R11
				cnt_d = '0; // R23
				off_d = '0; // R26
				half_d = split ? !half_q : 1'b0; // R18
			end
			else
			begin
				cnt_d = cnt_q + 6'h01;
				off_d = off_q + 4'h1; // R26
			end
		end
		if (seq_start && module_on)
			done_d = 1'b0; // R17
		if (irq_d)
			done_d = 1'b1; // R17
	end

	// Sequencing registers
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl1_q <= adc_seq_pkg::CTRL_RST;
			ctrl2_q <= adc_seq_pkg::CTRL_RST;
			ctrl3_q <= adc_seq_pkg::CTRL_RST;
			scan_q <= adc_seq_pkg::CTRL_RST;
			cnt_q <= '0;
			off_q <= '0;
			half_q <= 1'b0; // R27
			done_q <= 1'b0;
			irq_q <= 1'b0;
			restart_q <= 1'b0;
			power_q <= 1'b0;
		end
		else if (clk_en)
		begin
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			ctrl3_q <= ctrl3_d;
			scan_q <= scan_d;
			cnt_q <= cnt_d;
			off_q <= off_d;
			half_q <= half_d;
			done_q <= done_d;
			irq_q <= irq_d; // R11
			restart_q <= irq_d; // R23
			power_q <= ctrl1_d[adc_seq_pkg::C1_MODULE_ON]; // R06 R07
		end
	end

	// Result buffer write into the next entry of the active region
	always_ff @(posedge core_clk)
	begin
		if (clk_en && take_conv)
			result_mem[wr_idx] <= conv_data; // R10
	end

	assign converter_power = power_q;
	assign conv_irq = irq_q;
	assign seq_restart = restart_q;

endmodule

`default_nettype wire

/* File: sim/adc_seq_ctrl_monitor.sv */
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none

module adc_seq_ctrl_monitor
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic conv_valid,
	input wire logic converter_power,
	input wire logic conv_irq,
	input wire logic seq_restart,
	input wire logic [adc_seq_pkg::PIN_COUNT-1:0] digital_in_enable,
	input wire logic [adc_seq_pkg::PIN_COUNT-1:0] mux_to_ground
);
	// ==========================================
	// Clocking and accepted bus requests
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic take;
	assign take = clk_en && hsel && hready && htrans == adc_seq_pkg::HTRANS_NONSEQ;

	// ==========================================
	// Properties
	property p_pin_pair;
		digital_in_enable == mux_to_ground;
	endproperty
	a_pin_pair: assert property (p_pin_pair) else $error("pin gating mismatch");
	property p_pin_reset;
		$fell(rst) |-> digital_in_enable == '0 && mux_to_ground == '0;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pins not analog");
	property p_irq_restart;
		conv_irq == seq_restart;
	endproperty
	a_irq_restart: assert property (p_irq_restart) else $error("restart apart");
	property p_irq_cause;
		conv_irq |-> $past(conv_valid);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without result");
	property p_off_quiet;
		(!converter_power) [*3] |-> !conv_irq;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
	property p_rd_wait;
		take && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_zero;
		take && hwrite |=> hreadyout;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
	property p_okay;
		hresp == adc_seq_pkg::HRESP_OKAY;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
endmodule

bind adc_seq_ctrl adc_seq_ctrl_monitor i_mon
(
	.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.conv_valid(conv_valid), .converter_power(converter_power), .conv_irq(conv_irq),
	.seq_restart(seq_restart), .digital_in_enable(digital_in_enable),
	.mux_to_ground(mux_to_ground)
);

`default_nettype wire

/* File: sim/conv_source.sv */
// Converter core stand-in: a sequence start, then back-to-back results
`timescale 1ns/1ps
`default_nettype none

module conv_source
(
	input wire logic core_clk,
	input wire logic start,
	input wire logic [5:0] n,
	input wire logic [15:0] base,
	output logic seq_start,
	output logic conv_valid,
	output logic [15:0] conv_data,
	output logic busy
);
	// Idle data is inverted so a stale value is never mistaken for a result
	initial
	begin
		seq_start = 1'b0;
		conv_valid = 1'b0;
		conv_data = 16'hffff;
		busy = 1'b0;
		forever
		begin
			@(posedge core_clk);
			if (start)
			begin
				busy <= 1'b1;
				seq_start <= 1'b1;
				@(posedge core_clk);
				seq_start <= 1'b0;
				for (int i = 0; i < n; i++)
				begin
					conv_valid <= 1'b1;
					conv_data <= base + 16'(i);
					@(posedge core_clk);
				end
				conv_valid <= 1'b0;
				conv_data <= ~conv_data;
				busy <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

/* File: sim/adc_seq_ctrl_tb.sv */
// Testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none

module adc_seq_ctrl_tb;
	logic core_clk, rst, clk_en, hsel, hwrite, hreadyout, hresp, conv_valid, seq_start;
	logic converter_power, conv_irq, seq_restart, start, busy;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [15:0] conv_data, pin_in, base, digital_in_enable, mux_to_ground;
	logic [5:0] n;
	int errors, checks_done, cycles, irq_cnt, t;
	logic [15:0] c1_tab [5] = '{16'h8008, 16'h8000, 16'h8008, 16'h8000, 16'h8008};
	logic [15:0] c2_tab [5] = '{16'h0008, 16'h0104, 16'h0208, 16'h030c, 16'h0104};
	int ex_tab [5] = '{3, 2, 12, 4, 4};

	// ==========================================
	// Design and converter stand-in
	adc_seq_ctrl i_dut
	(
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_valid(conv_valid),
		.conv_data(conv_data), .seq_start(seq_start), .pin_in(pin_in),
		.converter_power(converter_power), .conv_irq(conv_irq), .seq_restart(seq_restart),
		.digital_in_enable(digital_in_enable), .mux_to_ground(mux_to_ground)
	);
	conv_source i_src
	(
		.core_clk(core_clk), .start(start), .n(n), .base(base), .seq_start(seq_start),
		.conv_valid(conv_valid), .conv_data(conv_data), .busy(busy)
	);

	// Clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Cycle limit and interrupt count
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (conv_irq === 1'b1)
			irq_cnt <= irq_cnt + 1;
		if (cycles == 20000)
		begin
			errors++;
			report_and_stop();
		end
	end

	// ==========================================
	// Tasks
	task report_and_stop();
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One single bus transfer; read data lands in rv
	task acc(input int w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		htrans <= adc_seq_pkg::HTRANS_NONSEQ;
		hwrite <= 1'(w);
		haddr <= {24'h000000, a};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask

	task run(input logic [5:0] k, input logic [15:0] b);
		@(posedge core_clk);
		start <= 1'b1;
		n <= k;
		base <= b;
		@(posedge core_clk);
		start <= 1'b0;
		do @(posedge core_clk); while (busy !== 1'b0);
		repeat (2) @(posedge core_clk);
	endtask

	// ==========================================
	// Test sequence
	initial
	begin
		rst = 1'b1;
		clk_en = 1'b1;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		pin_in = 16'h0ff0;
		start = 1'b0;
		n = 6'h00;
		base = 16'h0000;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		acc(0, adc_seq_pkg::OFS_CTRL2, 0);
		chk("ctrl2", 0, rv);
		acc(0, adc_seq_pkg::OFS_PINCFG, 0);
		chk("pincfg", 0, rv);
		chk("dig_en", 0, {16'h0000, digital_in_enable});
		acc(1, adc_seq_pkg::OFS_PINCFG, 32'h00f0);
		repeat (4) @(posedge core_clk);
		chk("dig_en", 32'h00f0, {16'h0000, digital_in_enable});
		chk("mux_gnd", 32'h00f0, {16'h0000, mux_to_ground});
		acc(0, adc_seq_pkg::OFS_PORT, 0);
		chk("port", 32'h00f0, rv);
		acc(0, 8'h30, 0);
		chk("unmapped", 0, rv);
		for (int m = 0; m < 5; m++)
		begin
			acc(1, adc_seq_pkg::OFS_CTRL1, 0);
			acc(1, adc_seq_pkg::OFS_CTRL2, {16'h0000, c2_tab[m]});
			chk("power_off", 0, {31'h0, converter_power});
			acc(1, adc_seq_pkg::OFS_CTRL1, {16'h0000, c1_tab[m]});
			repeat (4) @(posedge core_clk);
			chk("power_on", 1, {31'h0, converter_power});
			t = irq_cnt;
			run(6'(ex_tab[m] - 1), 16'(m * 256));
			acc(0, adc_seq_pkg::OFS_CTRL1, 0);
			chk("done_clr", {16'h0000, c1_tab[m]}, rv);
			chk("early_irq", t, irq_cnt);
			run(6'h01, 16'(m * 256 + ex_tab[m] - 1));
			chk("irq", t + 1, irq_cnt);
			acc(0, adc_seq_pkg::OFS_CTRL1, 0);
			chk("done", {16'h0000, c1_tab[m] | 16'h0001}, rv);
			for (int i = 0; i < ex_tab[m]; i++)
			begin
				acc(0, 8'(adc_seq_pkg::OFS_BUF_FIRST + 4 * i), 0);
				chk("buf", 32'(m * 256 + i), rv);
			end
		end
		acc(1, adc_seq_pkg::OFS_CTRL1, 0);
		// Results offered while off must be refused and leave the done flag alone
		t = irq_cnt;
		run(6'h02, 16'h0c00);
		chk("off_irq", t, irq_cnt);
		acc(0, adc_seq_pkg::OFS_CTRL1, 0);
		chk("off_done", 32'h0001, rv);
		acc(0, adc_seq_pkg::OFS_BUF_FIRST, 0);
		chk("off_buf", 32'h0400, rv);
		acc(1, adc_seq_pkg::OFS_CTRL2, 32'h0006);
		acc(1, adc_seq_pkg::OFS_CTRL1, 32'h8000);
		acc(0, adc_seq_pkg::OFS_CTRL2, 0);
		chk("half_low", 32'h0006, rv);
		run(6'h02, 16'h0a00);
		acc(0, adc_seq_pkg::OFS_CTRL2, 0);
		chk("half_up", 32'h0086, rv);
		run(6'h02, 16'h0b00);
		acc(0, adc_seq_pkg::OFS_CTRL2, 0);
		chk("half_back", 32'h0006, rv);
		// With the clock enable low a full sequence must leave no trace
		clk_en <= 1'b0;
		t = irq_cnt;
		run(6'h02, 16'h0d00);
		chk("frozen_irq", t, irq_cnt);
		clk_en <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			acc(0, 8'(adc_seq_pkg::OFS_BUF_FIRST + 4 * i), 0);
			chk("buf_low", 32'(16'h0a00 + i), rv);
			acc(0, 8'(adc_seq_pkg::OFS_BUF_FIRST + 32 + 4 * i), 0);
			chk("buf_up", 32'(16'h0b00 + i), rv);
		end
		report_and_stop();
	end
endmodule

`default_nettype wire
